// ---- dv/disc_motor_speed_pwm_tb.sv ----
`timescale 1ns/1ps
module disc_motor_speed_pwm_tb;
    import motor_pwm_pkg::*;
    localparam int PER = 284;
    localparam int BST = 2000;
    logic          MCLK_IN = 1'b0;
    logic          SYS_RST_IN = 1'b1;
    logic [5:0]    duty_in = 6'h20;
    logic          word_clk = 1'b1;
    logic          stop_req = 1'b0;
    logic          sense_pin;
    logic          motor_pin;
    od_drive_t     sense_drv;
    od_drive_t     motor_drv;
    motor_status_t status;
    int            n_mismatch = 0;
    int            checks = 0;
    int            cyc = 0;
    int            t0;
    logic [5:0]    corner [4] = '{6'h00, 6'h01, 6'h3F, 6'h20};

    always #20 MCLK_IN = ~MCLK_IN;
    always @(posedge MCLK_IN) cyc <= cyc + 1;
    // word clock released four cycles out of eight, long enough to sample
    always @(negedge MCLK_IN) word_clk <= cyc[2];

    disc_motor_speed_pwm #(.BURST_CYC(BST), .PERIOD_CYC(PER)) i_disc_motor_speed_pwm (
        .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .DUTY_CALC_IN(duty_in),
        .WORD_CLK_IN(word_clk), .SENSE_PIN_IN(sense_pin), .SENSE_PIN_OUT(sense_drv),
        .MOTOR_PWM_OUT(motor_drv), .STATUS_OUT(status));
    motor_driver_model i_motor_driver_model (
        .stop_req_in(stop_req), .sense_drv_in(sense_drv), .motor_drv_in(motor_drv),
        .sense_pin_out(sense_pin), .motor_pin_out(motor_pin));

    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic fail(string msg);
        n_mismatch++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask
    task automatic chk_cnt(int got, int exp);
        checks++;
        if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
    endtask
    task automatic chk_code(logic [5:0] got, logic [5:0] exp);
        checks++;
        if (got !== exp) fail($sformatf("duty code %h expected %h", got, exp));
    endtask
    task automatic chk_pin(logic got, logic exp);
        checks++;
        if (got !== exp) fail($sformatf("pin drive %b expected %b", got, exp));
    endtask
    // shared pin drive follows the word clock one edge late; word_clk is read
    // here before its own update at this edge, so it is the value the design took
    always @(negedge MCLK_IN) begin
        if (cyc > 8 && cyc % 61 == 0) chk_pin(sense_drv.oe_n, word_clk);
    end
    // high time of one period, clamped code times period over 64
    function automatic int exp_hi(logic [5:0] d);
        return (int'(d) * PER) / 64;
    endfunction
    task automatic wait_rise();
        logic p;
        p = motor_pin;
        for (int i = 0; i < 3 * PER; i++) begin
            @(negedge MCLK_IN);
            if (p === 1'b0 && motor_pin === 1'b1) return;
            p = motor_pin;
        end
        fail("no pwm edge");
        end_of_test();
    endtask
    task automatic wait_mode(motor_mode_t m);
        for (int i = 0; i < BST + 400; i++) begin
            if (status.mode === m) return;
            @(negedge MCLK_IN);
        end
        fail("mode not reached");
        end_of_test();
    endtask
    // measures the next whole period while the duty input is scrambled
    task automatic chk_period(logic [5:0] d);
        int hi;
        int lo;
        wait_rise();
        duty_in = 6'($urandom_range(63, 1));
        chk_code(status.duty, d);
        hi = 0;
        lo = 0;
        while (motor_pin === 1'b1 && hi < 2 * PER) begin
            hi++;
            @(negedge MCLK_IN);
        end
        while (motor_pin === 1'b0 && lo < 2 * PER) begin
            lo++;
            @(negedge MCLK_IN);
        end
        chk_cnt(hi, exp_hi(d));
        chk_cnt(hi + lo, PER);
    endtask
    task automatic chk_duty(logic [5:0] d);
        duty_in = d;
        wait_rise();
        chk_period((d == 6'h00) ? 6'h01 : d);
    endtask

    initial begin
        void'($urandom(9));
        repeat (3) @(negedge MCLK_IN);
        SYS_RST_IN = 1'b0;
        foreach (corner[i]) chk_duty(corner[i]);
        repeat (6) chk_duty(6'($urandom_range(63, 1)));
        $display("test duty done");
        stop_req = 1'b1;
        wait_mode(MODE_STOP_BURST);
        t0 = cyc;
        chk_period(6'h01);
        wait_mode(MODE_STOP_HOLD);
        chk_cnt(cyc - t0, BST);
        chk_period(6'h20);
        $display("test stop done");
        stop_req = 1'b0;
        wait_mode(MODE_START_BURST);
        t0 = cyc;
        chk_period(6'h3F);
        wait_mode(MODE_NORMAL);
        chk_cnt(cyc - t0, BST);
        chk_duty(6'($urandom_range(63, 1)));
        $display("test start done");
        end_of_test();
    end
endmodule

// ---- dv/motor_driver_model.sv ----
`timescale 1ns/1ps
// far side: pull-ups on both pins, a stop switch on the sense line
module motor_driver_model
    import motor_pwm_pkg::*;
(
    input  wire logic      stop_req_in,
    input  wire od_drive_t sense_drv_in,
    input  wire od_drive_t motor_drv_in,
    output logic           sense_pin_out,
    output logic           motor_pin_out
);
    // pull-up wins unless a party pulls low
    assign sense_pin_out = sense_drv_in.oe_n & ~stop_req_in;
    assign motor_pin_out = motor_drv_in.oe_n;
endmodule

// ---- inc/motor_pwm_cfg.svh ----
`ifndef MOTOR_PWM_CFG_SVH
`define MOTOR_PWM_CFG_SVH

// clock and pwm timing
`define CLK_HZ          25000000
`define PWM_RATE_HZ     88000
`define PWM_PERIOD_CYC  (`CLK_HZ / `PWM_RATE_HZ)
// duty factor in 64ths: 1/64 = 1,6 %, 63/64 = 98,4 %, 62 steps between
`define DUTY_SHIFT      6
`define DUTY_MIN        6'h01
`define DUTY_MAX        6'h3F
`define DUTY_HALF       6'h20
// forced bursts after a start or stop request
`define BURST_TIME_MS   200
`define BURST_CYC       ((`CLK_HZ / 1000) * `BURST_TIME_MS)
// cycles the sense pin must be released before it is sampled
`define SENSE_SETTLE    2'h2

`endif

// ---- inc/motor_pwm_pkg.sv ----
package motor_pwm_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_START_BURST,
        MODE_STOP_BURST,
        MODE_STOP_HOLD
    } motor_mode_t;

    // one open-drain pin as driven by the design; oe_n low = pulling low
    typedef struct packed {
        logic out;
        logic oe_n;
    } od_drive_t;

    typedef struct packed {
        motor_mode_t mode;
        logic [5:0]  duty;
    } motor_status_t;

endpackage

// ---- src/disc_motor_speed_pwm.sv ----
`timescale 1ns/1ps
`include "motor_pwm_cfg.svh"

// Notes on behaviour
// - the motor output is a pwm waveform repeating at 88 kHz that sets the disc data rate.
// - the duty factor is held between 1,6 % and 98,4 % in 62 steps.
// - a start request forces 98,4 % for 0,2 s, then the calculated duty returns.
// - a stop request forces 1,6 % for 0,2 s, then a steady 50 % until a start is seen.
// - the shared word clock / start-stop pin is sampled while released high; low is stop.
module disc_motor_speed_pwm
    import motor_pwm_pkg::*;
#(
    parameter int BURST_CYC  = `BURST_CYC,
    parameter int PERIOD_CYC = `PWM_PERIOD_CYC,
    parameter int CNT_W      = 9,
    parameter int BURST_W    = 23
) (
    input  wire logic          MCLK_IN,
    input  wire logic          SYS_RST_IN,
    input  wire logic [5:0]    DUTY_CALC_IN,
    input  wire logic          WORD_CLK_IN,
    input  wire logic          SENSE_PIN_IN,
    output od_drive_t          SENSE_PIN_OUT,
    output od_drive_t          MOTOR_PWM_OUT,
    output motor_status_t      STATUS_OUT
);

    // high time in clocks for a duty code, shared by pwm and checks
    // rounds down, so even the lowest code keeps a few clocks of high time
    function automatic logic [CNT_W-1:0] high_cycles(input logic [5:0] duty);
        logic [CNT_W+5:0] prod;
        prod = duty * PERIOD_CYC[CNT_W-1:0];
        return prod[CNT_W+5:`DUTY_SHIFT];
    endfunction

    // keeps the calculated duty inside the legal band
    function automatic logic [5:0] clamp_duty(input logic [5:0] duty);
        if (duty < `DUTY_MIN) begin
            return `DUTY_MIN;
        end
        return duty;
    endfunction

    logic [CNT_W-1:0]   cnt_r, cnt_nxt;
    logic [5:0]         duty_r, duty_nxt;
    logic               pwm_oe_n_r, pwm_oe_n_nxt;
    logic               boundary;
    logic [5:0]         target;

    logic               sense_oe_n_r, sense_oe_n_nxt;
    logic [1:0]         rel_age_r, rel_age_nxt;
    logic               stop_lvl_r, stop_lvl_nxt;
    logic               stop_evt, start_evt;

    motor_mode_t        mode_r, mode_nxt;
    logic [BURST_W-1:0] burst_r, burst_nxt;
    logic               burst_done;

    // sense pin: follow the word clock, sample only once released and settled
    always_comb begin
        sense_oe_n_nxt = WORD_CLK_IN;
        rel_age_nxt    = 2'h0;
        stop_lvl_nxt   = stop_lvl_r;
        if (sense_oe_n_r) begin
            rel_age_nxt = (rel_age_r == `SENSE_SETTLE) ? rel_age_r : rel_age_r + 2'h1;
        end
        // pull-up needs time to lift the line; an early sample would read a false stop
        if (sense_oe_n_r && rel_age_r == `SENSE_SETTLE) begin
            stop_lvl_nxt = !SENSE_PIN_IN;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            sense_oe_n_r <= 1'b0;
            rel_age_r    <= 2'h0;
            stop_lvl_r   <= 1'b0;
        end else begin
            sense_oe_n_r <= sense_oe_n_nxt;
            rel_age_r    <= rel_age_nxt;
            stop_lvl_r   <= stop_lvl_nxt;
        end
    end

    assign stop_evt  = stop_lvl_nxt && !stop_lvl_r;
    assign start_evt = !stop_lvl_nxt && stop_lvl_r;

    // mode sequencing; a new request restarts the burst timer
    assign burst_done = (burst_r == BURST_W'(BURST_CYC - 1));

    always_comb begin
        mode_nxt  = mode_r;
        burst_nxt = burst_r + BURST_W'(1);
        if (stop_evt) begin
            mode_nxt  = MODE_STOP_BURST;
            burst_nxt = '0;
        end else if (start_evt) begin
            mode_nxt  = MODE_START_BURST;
            burst_nxt = '0;
        end else begin
            case (mode_r)
                MODE_START_BURST: begin
                    if (burst_done) begin
                        mode_nxt = MODE_NORMAL;
                    end
                end
                MODE_STOP_BURST: begin
                    if (burst_done) begin
                        mode_nxt = MODE_STOP_HOLD;
                    end
                end
                default: begin
                    burst_nxt = burst_r;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            mode_r  <= MODE_NORMAL;
            burst_r <= '0;
        end else begin
            mode_r  <= mode_nxt;
            burst_r <= burst_nxt;
        end
    end

    // duty chosen by mode
    always_comb begin
        case (mode_r)
            MODE_START_BURST: target = `DUTY_MAX;
            MODE_STOP_BURST:  target = `DUTY_MIN;
            MODE_STOP_HOLD:   target = `DUTY_HALF;
            default:          target = clamp_duty(DUTY_CALC_IN);
        endcase
    end

    // period divider; duty only changes at the wrap so no pulse is cut short
    assign boundary = (cnt_r == CNT_W'(PERIOD_CYC - 1));

    always_comb begin
        cnt_nxt      = boundary ? '0 : cnt_r + CNT_W'(1);
        duty_nxt     = boundary ? target : duty_r;
        pwm_oe_n_nxt = (cnt_nxt < high_cycles(duty_nxt));
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            // park on the last count so the first period after reset is whole
            cnt_r      <= CNT_W'(PERIOD_CYC - 1);
            duty_r     <= `DUTY_HALF;
            pwm_oe_n_r <= 1'b0;
        end else begin
            cnt_r      <= cnt_nxt;
            duty_r     <= duty_nxt;
            pwm_oe_n_r <= pwm_oe_n_nxt;
        end
    end

    // outputs straight from flops; drive value is always low for open drain
    assign SENSE_PIN_OUT.out  = 1'b0;
    assign SENSE_PIN_OUT.oe_n = sense_oe_n_r;
    assign MOTOR_PWM_OUT.out  = 1'b0;
    assign MOTOR_PWM_OUT.oe_n = pwm_oe_n_r;
    assign STATUS_OUT.mode    = mode_r;
    assign STATUS_OUT.duty    = duty_r;

    // checks
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // all checks stay quiet while reset is held

    AST_PERIOD_WRAP: assert property (boundary |=> cnt_r == '0)
        else $error("pwm counter did not wrap at period end");

    AST_PERIOD_LEN: assert property (cnt_r == '0 |-> ##(PERIOD_CYC - 1) boundary)
        else $error("pwm period length wrong");

    AST_DUTY_BAND: assert property (duty_r >= `DUTY_MIN && duty_r <= `DUTY_MAX)
        else $error("duty factor outside band");

    AST_HIGH_TIME: assert property (cnt_r == '0 |->
        pwm_oe_n_r == (high_cycles(duty_r) != '0))
        else $error("pwm level at period start disagrees with duty");

    AST_START_MAX: assert property (boundary && mode_r == MODE_START_BURST
        |=> duty_r == `DUTY_MAX)
        else $error("start burst not at maximum duty");

    AST_START_END: assert property (mode_r == MODE_START_BURST && burst_done
        && !stop_evt && !start_evt |=> mode_r == MODE_NORMAL)
        else $error("start burst did not end on time");

    AST_STOP_MIN: assert property (boundary && mode_r == MODE_STOP_BURST
        |=> duty_r == `DUTY_MIN)
        else $error("stop burst not at minimum duty");

    AST_STOP_HOLD: assert property (mode_r == MODE_STOP_BURST && burst_done
        && !stop_evt && !start_evt |=> mode_r == MODE_STOP_HOLD)
        else $error("stop burst not followed by hold");

    AST_HOLD_HALF: assert property (boundary && mode_r == MODE_STOP_HOLD
        |=> duty_r == `DUTY_HALF)
        else $error("hold mode not at half duty");

    AST_SAMPLE_RELEASED: assert property (!$stable(stop_lvl_r)
        |-> $past(sense_oe_n_r, 1) && $past(rel_age_r, 1) == `SENSE_SETTLE)
        else $error("sense sampled while pin driven low");

    // the shared pin carries the word clock one edge late
    AST_SENSE_FOLLOW: assert property (1'b1 |=> sense_oe_n_r == $past(WORD_CLK_IN))
        else $error("shared pin drive does not follow the word clock");

    AST_DUTY_HELD: assert property (!boundary |=> $stable(duty_r))
        else $error("duty changed inside a period");

    COV_START: cover property (start_evt ##1 mode_r == MODE_START_BURST);
    COV_STOP: cover property (stop_evt ##1 mode_r == MODE_STOP_BURST);
    COV_HOLD: cover property (mode_r == MODE_STOP_BURST ##1 mode_r == MODE_STOP_HOLD);
    COV_BACK: cover property (mode_r == MODE_START_BURST ##1 mode_r == MODE_NORMAL);

endmodule
